// ==== src/ceb_defs.svh ====
`ifndef CEB_DEFS_SVH
`define CEB_DEFS_SVH
`define CEB_PIN_ACTIVE   1'b0
`define CEB_PIN_INACTIVE 1'b1
`define CEB_SHUTDOWN_CMD 2'h1
`define CEB_IDLE_CMD     2'h0
`endif

// ==== src/ceb_pkg.sv ====
package ceb_pkg;
  typedef enum logic [1:0] {
    CEB_RUN   = 2'b00,
    CEB_STOP  = 2'b01,
    CEB_BREAK = 2'b10
  } ceb_state_t;
endpackage

// ==== src/ceb_error_break.sv ====
// How it works
// [RULE1] Stop-clock inactive: error/break output shows an unmasked floating-point error.
// [RULE2] Stop-clock active: error/break output shows a pending break event needing service.
// [RULE3] A signalled break event holds the output asserted until stop-clock deasserts.
// [RULE4] Probe request during stop-clock counts as a break event.
// [RULE5] Either bus agent requests a snoop stall by driving hit and hit-modified together.
// [RULE6] An internal error asserts internal-error and issues a shutdown transaction; the code issues it only when internal-error is not already asserted.
// [RULE7] Internal-error stays asserted until reset, bus-init or init asserts.
// [RULE8] Ignore-numeric-error asserted: pending numeric error is disregarded, execution continues.
// [RULE9] Ignore deasserted: noncontrol floating-point instruction faults after an earlier error.
// [RULE10] Ignore input has no effect while the native numeric-error bit is set.
// [RULE11] Ignore input is asynchronous; outside party holds it valid at target-ready.
// [RULE12] Error/break, internal-error and hit outputs are active low.
`timescale 1ns/1ps
`include "ceb_defs.svh"
module ceb_error_break
  import ceb_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       stop_clock_in_n,
  input  wire logic       probe_request_in_n,
  input  wire logic       bus_initialize_in_n,
  input  wire logic       init_in_n,
  input  wire logic       ignore_numeric_error_in_n,
  input  wire logic       native_numeric_error_bit,
  input  wire logic       fp_error_detect,
  input  wire logic       fp_error_clear,
  input  wire logic       break_event,
  input  wire logic       fp_noncontrol_issue,
  input  wire logic       internal_error_event,
  input  wire logic       snoop_stall_req,
  input  wire logic       snoop_hit_in_n,
  input  wire logic       snoop_hit_modified_in_n,
  output logic            fp_error_or_break_out_n,
  output logic            internal_error_out_n,
  output logic            snoop_hit_out_n,
  output logic            snoop_hit_oe,
  output logic            snoop_hit_modified_n,
  output logic            snoop_hit_modified_oe,
  output logic            fp_exception,
  output logic            fp_ignored,
  output logic            peer_snoop_stall,
  output logic [1:0]      bus_special_cmd
);

  // Pins from outside the clock domain pass two flops; only stage two is read.
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] raw_in;
  assign raw_in = {snoop_hit_modified_in_n, snoop_hit_in_n, ignore_numeric_error_in_n,
                   init_in_n, bus_initialize_in_n, probe_request_in_n}; // see [RULE11]
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_ff[gi] <= `CEB_PIN_INACTIVE;
          sync2_ff[gi] <= `CEB_PIN_INACTIVE;
        end
        else
        begin
          sync1_ff[gi] <= raw_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  logic probe_s_n;
  logic bus_init_s_n;
  logic init_s_n;
  logic ignore_s_n;
  logic hit_s_n;
  logic hit_mod_s_n;
  logic stop_s_n;
  logic stop1_ff;
  logic stop2_ff;
  assign probe_s_n    = sync2_ff[0];
  assign bus_init_s_n = sync2_ff[1];
  assign init_s_n     = sync2_ff[2];
  assign ignore_s_n   = sync2_ff[3];
  assign hit_s_n      = sync2_ff[4];
  assign hit_mod_s_n  = sync2_ff[5];
  assign stop_s_n     = stop2_ff;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stop1_ff <= `CEB_PIN_INACTIVE;
      stop2_ff <= `CEB_PIN_INACTIVE;
    end
    else
    begin
      stop1_ff <= stop_clock_in_n;
      stop2_ff <= stop1_ff;
    end
  end

  // Error/break multiplexing state.
  ceb_state_t state_ff;
  ceb_state_t nxt_state;
  logic       fp_err_ff;
  logic       nxt_fp_err;
  logic       mux_n_ff;
  logic       nxt_mux_n;
  logic       stop_act;
  assign stop_act = (stop_s_n == `CEB_PIN_ACTIVE);

  always_comb
  begin
    nxt_state  = state_ff;
    // A new error wins over a clear in the same cycle.
    nxt_fp_err = fp_error_detect | (fp_err_ff & ~fp_error_clear);
    case (state_ff)
      CEB_RUN:
      begin
        if (stop_act)
          nxt_state = CEB_STOP;
      end
      CEB_STOP:
      begin
        if (!stop_act)
          nxt_state = CEB_RUN;
        else if (break_event || probe_s_n == `CEB_PIN_ACTIVE) // see [RULE4]
          nxt_state = CEB_BREAK; // see [RULE2]
      end
      CEB_BREAK:
      begin
        if (!stop_act)
          nxt_state = CEB_RUN; // see [RULE3]
      end
      default: nxt_state = CEB_RUN;
    endcase
    if (nxt_state == CEB_BREAK)
      nxt_mux_n = `CEB_PIN_ACTIVE; // see [RULE12]
    else if (nxt_state == CEB_RUN && nxt_fp_err)
      nxt_mux_n = `CEB_PIN_ACTIVE; // see [RULE1]
    else
      nxt_mux_n = `CEB_PIN_INACTIVE;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff  <= CEB_RUN;
      fp_err_ff <= 1'b0;
      mux_n_ff  <= `CEB_PIN_INACTIVE;
    end
    else
    begin
      state_ff  <= nxt_state;
      fp_err_ff <= nxt_fp_err;
      mux_n_ff  <= nxt_mux_n;
    end
  end
  assign fp_error_or_break_out_n = mux_n_ff;

  // Numeric error gating on noncontrol instructions.
  logic fpx_ff;
  logic nxt_fpx;
  logic fpi_ff;
  logic nxt_fpi;
  logic ignore_eff;
  // The native bit overrides the pin entirely.
  assign ignore_eff = (ignore_s_n == `CEB_PIN_ACTIVE) & ~native_numeric_error_bit; // see [RULE10]

  always_comb
  begin
    nxt_fpx = fp_noncontrol_issue & fp_err_ff & ~ignore_eff; // see [RULE9]
    nxt_fpi = fp_noncontrol_issue & fp_err_ff & ignore_eff;  // see [RULE8]
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fpx_ff <= 1'b0;
      fpi_ff <= 1'b0;
    end
    else
    begin
      fpx_ff <= nxt_fpx;
      fpi_ff <= nxt_fpi;
    end
  end
  assign fp_exception = fpx_ff;
  assign fp_ignored   = fpi_ff;

  // Internal error is sticky; only reset, bus-init or init release it.
  logic       interr_n_ff;
  logic       nxt_interr_n;
  logic [1:0] cmd_ff;
  logic [1:0] nxt_cmd;
  logic       clr_interr;
  assign clr_interr = (bus_init_s_n == `CEB_PIN_ACTIVE) | (init_s_n == `CEB_PIN_ACTIVE);

  always_comb
  begin
    nxt_interr_n = interr_n_ff;
    nxt_cmd      = `CEB_IDLE_CMD;
    // A new error wins over a held clear, so that no error is ever lost.
    if (internal_error_event)
    begin
      nxt_interr_n = `CEB_PIN_ACTIVE; // see [RULE6]
      // Only the first assertion issues a shutdown, so repeats cannot flood the bus.
      nxt_cmd      = (interr_n_ff == `CEB_PIN_INACTIVE) ? `CEB_SHUTDOWN_CMD : `CEB_IDLE_CMD;
    end
    else if (clr_interr)
      nxt_interr_n = `CEB_PIN_INACTIVE; // see [RULE7]
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interr_n_ff <= `CEB_PIN_INACTIVE;
      cmd_ff      <= `CEB_IDLE_CMD;
    end
    else
    begin
      interr_n_ff <= nxt_interr_n;
      cmd_ff      <= nxt_cmd;
    end
  end
  assign internal_error_out_n = interr_n_ff;
  assign bus_special_cmd      = cmd_ff;

  // Snoop stall: both hit lines driven low together, open-drain style.
  // The synchronisers still show our own drive for two edges after release, so that echo
  // is masked. A peer stall overlapping our own cannot be told apart on a wired line.
  logic       stall_drv_ff;
  logic       nxt_stall_drv;
  logic [1:0] own_echo_ff;
  logic [1:0] nxt_own_echo;
  logic       hit_lvl_n_ff;
  logic       nxt_hit_lvl_n;
  logic       peer_ff;
  logic       nxt_peer;

  always_comb
  begin
    nxt_stall_drv = snoop_stall_req; // see [RULE5]
    nxt_own_echo  = {own_echo_ff[0], stall_drv_ff};
    nxt_hit_lvl_n = snoop_stall_req ? `CEB_PIN_ACTIVE : `CEB_PIN_INACTIVE; // see [RULE12]
    nxt_peer      = (hit_s_n == `CEB_PIN_ACTIVE) & (hit_mod_s_n == `CEB_PIN_ACTIVE)
                    & ~stall_drv_ff & ~(|own_echo_ff);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stall_drv_ff <= 1'b0;
      own_echo_ff  <= 2'h0;
      hit_lvl_n_ff <= `CEB_PIN_INACTIVE;
      peer_ff      <= 1'b0;
    end
    else
    begin
      stall_drv_ff <= nxt_stall_drv;
      own_echo_ff  <= nxt_own_echo;
      hit_lvl_n_ff <= nxt_hit_lvl_n;
      peer_ff      <= nxt_peer;
    end
  end
  assign snoop_hit_out_n       = hit_lvl_n_ff;
  assign snoop_hit_modified_n  = hit_lvl_n_ff;
  assign snoop_hit_oe          = stall_drv_ff;
  assign snoop_hit_modified_oe = stall_drv_ff;
  assign peer_snoop_stall      = peer_ff;

  a_break_held: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE3]
    (state_ff == CEB_BREAK && stop_act) |=> fp_error_or_break_out_n == `CEB_PIN_ACTIVE)
    else $error("break not held");
  a_break_probe: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE4]
    (state_ff == CEB_STOP && stop_act && probe_s_n == `CEB_PIN_ACTIVE)
      |=> state_ff == CEB_BREAK)
    else $error("probe not a break");
  a_fp_err_run: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE1]
    (state_ff == CEB_RUN && fp_err_ff) |-> fp_error_or_break_out_n == `CEB_PIN_ACTIVE)
    else $error("fp error not shown");
  a_stop_mask: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE2]
    (state_ff == CEB_STOP) |-> fp_error_or_break_out_n == `CEB_PIN_INACTIVE)
    else $error("error shown during stop");
  a_int_err_sticky: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE7]
    (internal_error_out_n == `CEB_PIN_ACTIVE && !clr_interr)
      |=> internal_error_out_n == `CEB_PIN_ACTIVE)
    else $error("internal error dropped");
  a_int_err_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE7]
    (clr_interr && !internal_error_event) |=> internal_error_out_n == `CEB_PIN_INACTIVE)
    else $error("internal error not cleared");
  a_int_err_set: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE6]
    (internal_error_event && internal_error_out_n == `CEB_PIN_INACTIVE)
      |=> (internal_error_out_n == `CEB_PIN_ACTIVE && bus_special_cmd == `CEB_SHUTDOWN_CMD))
    else $error("internal error not raised");
  a_native_override: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE10]
    (native_numeric_error_bit && fp_noncontrol_issue && fp_err_ff)
      |=> (fp_exception && !fp_ignored))
    else $error("native bit not honoured");
  a_ignore_pin: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE8]
    (ignore_s_n == `CEB_PIN_ACTIVE && !native_numeric_error_bit && fp_noncontrol_issue
      && fp_err_ff) |=> (fp_ignored && !fp_exception))
    else $error("ignored error faulted");
  a_stall_pair: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE5]
    $rose(snoop_stall_req) |=> (snoop_hit_oe && snoop_hit_modified_oe
      && snoop_hit_out_n == `CEB_PIN_ACTIVE && snoop_hit_modified_n == `CEB_PIN_ACTIVE))
    else $error("stall lines not paired");
  a_peer_echo: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE5]
    (stall_drv_ff || (|own_echo_ff)) |=> !peer_snoop_stall)
    else $error("own stall seen as peer");
  c_break: cover property (@(posedge core_clk) disable iff (!rst_n) state_ff == CEB_BREAK);
  c_int_err: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(internal_error_out_n));
  c_fpx: cover property (@(posedge core_clk) disable iff (!rst_n) fp_exception);
  c_peer: cover property (@(posedge core_clk) disable iff (!rst_n) peer_snoop_stall);

endmodule // ceb_error_break

// ==== dv/ceb_core_logic_model.sv ====
`timescale 1ns/1ps
module ceb_core_logic_model
(
  input  wire logic stop_req,
  input  wire logic probe_req,
  input  wire logic bus_init_req,
  input  wire logic init_req,
  input  wire logic ignore_req,
  input  wire logic peer_stall_req,
  input  wire logic dev_hit_n,
  input  wire logic dev_hit_oe,
  input  wire logic dev_hit_mod_n,
  input  wire logic dev_hit_mod_oe,
  output logic      stop_clock_in_n,
  output logic      probe_request_in_n,
  output logic      bus_initialize_in_n,
  output logic      init_in_n,
  output logic      ignore_numeric_error_in_n,
  output logic      hit_wire_n,
  output logic      hit_mod_wire_n
);
  assign stop_clock_in_n     = ~stop_req;
  assign probe_request_in_n  = ~probe_req;
  assign bus_initialize_in_n = ~bus_init_req;
  assign init_in_n           = ~init_req;
  // Held as a level, so it is valid at any target-ready sample point.
  assign ignore_numeric_error_in_n = ~ignore_req;
  // Pulled-up shared lines read low only when an agent enables a low level onto them.
  assign hit_wire_n     = ~(peer_stall_req | (dev_hit_oe & ~dev_hit_n));
  assign hit_mod_wire_n = ~(peer_stall_req | (dev_hit_mod_oe & ~dev_hit_mod_n));
endmodule // ceb_core_logic_model

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "ceb_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic       core_clk, rst_n, stop_req, probe_req, bus_init_req, init_req, ign_req;
  logic       peer_req, native_bit, fp_det, fp_clr, brk, fp_issue, ie_evt, stall_req;
  logic       stop_n, probe_n, bus_init_n, init_n, ign_n, hit_n, hit_mod_n;
  logic       fp_out_n, ie_out_n, hit_drv_n, hit_oe, hit_mod_drv_n, hit_mod_oe;
  logic       fp_exc, fp_ign, peer_stall;
  logic [1:0] cmd;
  logic [31:0] rng;
  logic       exp_ign;
  int         mismatches, compares, j;

  ceb_core_logic_model far (.stop_req(stop_req), .probe_req(probe_req),
    .bus_init_req(bus_init_req), .init_req(init_req), .ignore_req(ign_req),
    .peer_stall_req(peer_req), .dev_hit_n(hit_drv_n), .dev_hit_oe(hit_oe),
    .dev_hit_mod_n(hit_mod_drv_n), .dev_hit_mod_oe(hit_mod_oe),
    .stop_clock_in_n(stop_n), .probe_request_in_n(probe_n),
    .bus_initialize_in_n(bus_init_n), .init_in_n(init_n),
    .ignore_numeric_error_in_n(ign_n), .hit_wire_n(hit_n), .hit_mod_wire_n(hit_mod_n));

  ceb_error_break uut (.core_clk(core_clk), .rst_n(rst_n), .stop_clock_in_n(stop_n),
    .probe_request_in_n(probe_n), .bus_initialize_in_n(bus_init_n), .init_in_n(init_n),
    .ignore_numeric_error_in_n(ign_n), .native_numeric_error_bit(native_bit),
    .fp_error_detect(fp_det), .fp_error_clear(fp_clr), .break_event(brk),
    .fp_noncontrol_issue(fp_issue), .internal_error_event(ie_evt),
    .snoop_stall_req(stall_req), .snoop_hit_in_n(hit_n),
    .snoop_hit_modified_in_n(hit_mod_n), .fp_error_or_break_out_n(fp_out_n),
    .internal_error_out_n(ie_out_n), .snoop_hit_out_n(hit_drv_n), .snoop_hit_oe(hit_oe),
    .snoop_hit_modified_n(hit_mod_drv_n), .snoop_hit_modified_oe(hit_mod_oe),
    .fp_exception(fp_exc), .fp_ignored(fp_ign), .peer_snoop_stall(peer_stall),
    .bus_special_cmd(cmd));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    #50000;
    mismatches++;
    final_report();
  end

  initial
  begin
    {stop_req, probe_req, bus_init_req, init_req, ign_req, peer_req} = 6'h00;
    {native_bit, fp_det, fp_clr, brk, fp_issue, ie_evt, stall_req} = 7'h00;
    rst_n = 1'b0;
    rng = 32'h3cd50db0;
    repeat (16) @(posedge core_clk);
    #1 rst_n = 1'b1;
    step(3);
    `CHK(fp_out_n, `CEB_PIN_INACTIVE)
    `CHK(ie_out_n, `CEB_PIN_INACTIVE)
    `CHK(hit_n, `CEB_PIN_INACTIVE)
    fp_det = 1'b1;
    step(1);
    fp_det = 1'b0;
    `CHK(fp_out_n, `CEB_PIN_ACTIVE)
    fp_clr = 1'b1;
    step(1);
    fp_clr = 1'b0;
    `CHK(fp_out_n, `CEB_PIN_INACTIVE)
    $display("test fp error done");
    for (j = 0; j < 2; j++)
    begin
      brk = 1'b1;
      step(2);
      brk = 1'b0;
      `CHK(fp_out_n, `CEB_PIN_INACTIVE)
      fp_det = 1'b1;
      step(1);
      fp_det = 1'b0;
      stop_req = 1'b1;
      step(4);
      `CHK(fp_out_n, `CEB_PIN_INACTIVE)
      if (j == 0)
        brk = 1'b1;
      else
        probe_req = 1'b1;
      step(4);
      brk = 1'b0;
      probe_req = 1'b0;
      `CHK(fp_out_n, `CEB_PIN_ACTIVE)
      fp_clr = 1'b1;
      step(6);
      fp_clr = 1'b0;
      `CHK(fp_out_n, `CEB_PIN_ACTIVE)
      stop_req = 1'b0;
      step(4);
      `CHK(fp_out_n, `CEB_PIN_INACTIVE)
    end
    $display("test break event done");
    for (j = 0; j < 2; j++)
    begin
      ie_evt = 1'b1;
      step(1);
      ie_evt = 1'b0;
      `CHK(ie_out_n, `CEB_PIN_ACTIVE)
      `CHK(cmd, `CEB_SHUTDOWN_CMD)
      ie_evt = 1'b1;
      step(1);
      ie_evt = 1'b0;
      `CHK(cmd, `CEB_IDLE_CMD)
      step(5);
      `CHK(ie_out_n, `CEB_PIN_ACTIVE)
      if (j == 0)
        bus_init_req = 1'b1;
      else
        init_req = 1'b1;
      step(4);
      `CHK(ie_out_n, `CEB_PIN_INACTIVE)
      bus_init_req = 1'b0;
      init_req = 1'b0;
      step(4);
    end
    $display("test internal error done");
    for (j = 0; j < 8; j++)
    begin
      rng = xs(rng);
      // The first two passes pin the ignore cases so both outcomes always run.
      ign_req = (j < 2) ? 1'b1 : rng[0];
      native_bit = (j == 1) ? 1'b1 : ((j == 0) ? 1'b0 : rng[1]);
      exp_ign = ign_req & ~native_bit;
      fp_det = 1'b1;
      step(1);
      fp_det = 1'b0;
      step(4);
      fp_issue = 1'b1;
      step(1);
      fp_issue = 1'b0;
      `CHK(fp_exc, ~exp_ign)
      `CHK(fp_ign, exp_ign)
      fp_clr = 1'b1;
      step(1);
      fp_clr = 1'b0;
      fp_issue = 1'b1;
      step(1);
      fp_issue = 1'b0;
      `CHK(fp_exc, 1'b0)
      `CHK(fp_ign, 1'b0)
    end
    $display("test numeric error done");
    stall_req = 1'b1;
    step(1);
    `CHK(hit_oe, 1'b1)
    `CHK(hit_mod_oe, 1'b1)
    `CHK(hit_n, `CEB_PIN_ACTIVE)
    `CHK(hit_mod_n, `CEB_PIN_ACTIVE)
    stall_req = 1'b0;
    // Our own drive echoes through the synchronisers and must not look like a peer stall.
    repeat (4)
    begin
      step(1);
      `CHK(peer_stall, 1'b0)
    end
    `CHK(hit_mod_n, `CEB_PIN_INACTIVE)
    peer_req = 1'b1;
    step(4);
    `CHK(peer_stall, 1'b1)
    peer_req = 1'b0;
    step(4);
    `CHK(peer_stall, 1'b0)
    $display("test snoop stall done");
    final_report();
  end
endmodule // testbench
